// ===== common/msf_map.svh
// Purpose: register offsets, field positions, reset values and timing figures
// Assumes: byte addresses on a 12-bit APB address, one 32-bit word each
// Notes: definitions only
`ifndef MSF_MAP_SVH
`define MSF_MAP_SVH
// ==========================================================================
// register offsets
`define MSF_ADDR_CAUSE 12'h000
`define MSF_ADDR_CTRL 12'h004
`define MSF_ADDR_STAT 12'h008
`define MSF_ADDR_TXDATA 12'h00C
`define MSF_ADDR_RXDATA 12'h010
// ==========================================================================
// cause bit positions
`define MSF_BIT_LOWBAT 7
`define MSF_BIT_RESET 6
`define MSF_BIT_ELEC 5
`define MSF_BIT_FLOW 4
`define MSF_BIT_S2SHORT 3
`define MSF_BIT_S2OPEN 2
`define MSF_BIT_S1SHORT 1
`define MSF_BIT_S1OPEN 0
// causes that stop energy calculation
`define MSF_ENERGY_MASK 8'h3F
// causes that stop volume calculation
`define MSF_VOLUME_MASK 8'h10
// ==========================================================================
// control and status fields
`define MSF_CTRL_OPT_EN 0
`define MSF_CTRL_RESET 1'h1
`define MSF_STAT_OPEN 0
`define MSF_STAT_MAINS 1
`define MSF_STAT_TXBUSY 2
`define MSF_STAT_SHOWBIN 3
`define MSF_STAT_CRED_LSB 8
`define MSF_RX_VALID_BIT 8
// ==========================================================================
// timing and link figures
`define MSF_CLK_HZ 125000000
`define MSF_BAUD 2400
`define MSF_SESSION_S 4
`define MSF_DAY_S 86400
`define MSF_ALT_S 2
`define MSF_DAILY_CREDIT 4
`define MSF_CREDIT_MAX 32
`define MSF_WAKE_BYTE 8'h55
`define MSF_HDR_LEN 4
`endif

// ===== common/msf_pkg.sv
// Purpose: shared types and helpers of the meter status and optical block
// Assumes: nothing
// Notes: constants live in msf_map.svh
package msf_pkg;
  typedef enum logic [2:0] {
    sess_idle = 3'h1,
    sess_hdr = 3'h2,
    sess_open = 3'h4
  } msf_sess_t;

  // display position n+1 holds cause bit 7-n
  function automatic logic [7:0] msf_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : msf_rev8
endpackage : msf_pkg

// ===== common/msf_uart_if.sv
// Purpose: character path between the session core and the serial engine
// Assumes: single clock pclk
// Notes: rx_valid is a one-cycle pulse
`timescale 1ns/1ps
interface msf_uart_if;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_err;
  logic [7:0] tx_data;
  logic tx_start;
  logic tx_busy;
  modport uart (output rx_data, rx_valid, rx_err, tx_busy,
                input tx_data, tx_start);
  modport core (input rx_data, rx_valid, rx_err, tx_busy,
                output tx_data, tx_start);
endinterface : msf_uart_if

// ===== src/msf_uart.sv
// Purpose: 8N1 serial receiver and transmitter for the optical port
// Assumes: rxd synchronous to pclk, idle high
// Notes: tx_start while busy is ignored
`timescale 1ns/1ps
module msf_uart #(
  parameter int BAUD_DIV = 52083
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // optical line
  input wire logic rxd,
  output logic txd,
  // character path
  msf_uart_if.uart u
);
  if (BAUD_DIV < 4 || BAUD_DIV > 65535) begin : g_bad_div
    $error("msf_uart: BAUD_DIV out of range");
  end

  localparam logic [15:0] DIV_M1 = 16'(BAUD_DIV - 1);
  localparam logic [15:0] DIV_H = 16'(BAUD_DIV / 2);

  logic rx_busy_reg, rx_busy_next;
  logic [15:0] rx_cnt_reg, rx_cnt_next;
  logic [3:0] rx_bit_reg, rx_bit_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic [7:0] rx_data_reg, rx_data_next;
  logic rx_valid_reg, rx_valid_next;
  logic rx_err_reg, rx_err_next;
  logic tx_busy_reg, tx_busy_next;
  logic [15:0] tx_cnt_reg, tx_cnt_next;
  logic [3:0] tx_bit_reg, tx_bit_next;
  logic [8:0] tx_sh_reg, tx_sh_next;
  logic txd_reg, txd_next;

  // ========================================================================
  // receive and transmit sequencing
  always_comb begin
    rx_busy_next = rx_busy_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    rx_data_next = rx_data_reg;
    rx_valid_next = 1'b0;
    rx_err_next = rx_err_reg;
    if (!rx_busy_reg) begin
      if (!rxd) begin
        rx_busy_next = 1'b1;
        rx_cnt_next = DIV_H;
        rx_bit_next = 4'h0;
      end
    end else if (rx_cnt_reg != 16'h0000) begin
      rx_cnt_next = rx_cnt_reg - 16'h0001;
    end else begin
      rx_cnt_next = DIV_M1;
      if (rx_bit_reg == 4'h0) begin
        // glitch shorter than half a bit is not a start bit
        rx_busy_next = !rxd;
        rx_bit_next = 4'h1;
      end else if (rx_bit_reg != 4'h9) begin
        rx_sh_next = {rxd, rx_sh_reg[7:1]};
        rx_bit_next = rx_bit_reg + 4'h1;
      end else begin
        rx_busy_next = 1'b0;
        rx_valid_next = 1'b1;
        rx_err_next = !rxd;
        rx_data_next = rx_sh_reg;
      end
    end
    tx_busy_next = tx_busy_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_bit_next = tx_bit_reg;
    tx_sh_next = tx_sh_reg;
    txd_next = txd_reg;
    if (!tx_busy_reg) begin
      if (u.tx_start) begin
        tx_busy_next = 1'b1;
        tx_cnt_next = DIV_M1;
        tx_bit_next = 4'h0;
        tx_sh_next = {1'b1, u.tx_data};
        txd_next = 1'b0;
      end
    end else if (tx_cnt_reg != 16'h0000) begin
      tx_cnt_next = tx_cnt_reg - 16'h0001;
    end else if (tx_bit_reg == 4'h9) begin
      tx_busy_next = 1'b0;
    end else begin
      tx_cnt_next = DIV_M1;
      txd_next = tx_sh_reg[0];
      tx_sh_next = {1'b1, tx_sh_reg[8:1]};
      tx_bit_next = tx_bit_reg + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_busy_reg <= 1'b0;
      rx_cnt_reg <= 16'h0000;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      rx_data_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
      rx_err_reg <= 1'b0;
      tx_busy_reg <= 1'b0;
      tx_cnt_reg <= 16'h0000;
      tx_bit_reg <= 4'h0;
      tx_sh_reg <= 9'h1FF;
      txd_reg <= 1'b1;
    end else begin
      rx_busy_reg <= rx_busy_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg <= rx_sh_next;
      rx_data_reg <= rx_data_next;
      rx_valid_reg <= rx_valid_next;
      rx_err_reg <= rx_err_next;
      tx_busy_reg <= tx_busy_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      tx_sh_reg <= tx_sh_next;
      txd_reg <= txd_next;
    end
  end

  assign u.rx_data = rx_data_reg;
  assign u.rx_valid = rx_valid_reg;
  assign u.rx_err = rx_err_reg;
  assign u.tx_busy = tx_busy_reg;
  assign txd = txd_reg;
endmodule : msf_uart

// ===== src/msf_top.sv
// Purpose: optical readout session, read-out budget and status byte display
// Assumes: all inputs synchronous to pclk; exch_ok comes from the protocol
//   layer, one pulse per completed valid exchange
// Notes: APB slave with zero wait states
`timescale 1ns/1ps
`include "msf_map.svh"

// Operation
// - session wakes only on received wake header
// - optical characters run at 2400 baud
// - header opens a four second session
// - valid exchange extends session four seconds
// - expiry closes session, display off
// - budget grants at least four sessions daily
// - unused budget accumulates across days
// - external supply lights the mains icon
// - battery takes over when supply fails
// - any active cause lights warning symbol
// - status alternates between hex and binary
// - eight independent causes in one byte
// - bits 7..4: battery, reset, electronics, flow
// - bits 3..0: sensor 2/1 short, open
// - binary shows bit 7 leftmost, bit 0 rightmost
// - electronics fault freezes energy register
// - flow fault freezes volume and energy
// - sensor fault freezes energy register
// - battery and reset causes are informational
module msf_top #(
  parameter int BAUD_DIV = `MSF_CLK_HZ / `MSF_BAUD,
  parameter int SESSION_CYC = `MSF_SESSION_S * `MSF_CLK_HZ,
  parameter int ALT_CYC = `MSF_ALT_S * `MSF_CLK_HZ,
  parameter logic [47:0] DAY_CYC = 48'(`MSF_DAY_S) * 48'(`MSF_CLK_HZ),
  parameter int HDR_LEN = `MSF_HDR_LEN,
  parameter int CREDIT_MAX = `MSF_CREDIT_MAX
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // optical link
  input wire logic opt_rxd,
  output logic opt_txd,
  input wire logic exch_ok,
  // fault sources and supply
  input wire logic [7:0] cause_in,
  input wire logic ext_supply_det,
  // display and calculation control
  output logic session_open,
  output logic disp_on,
  output logic disp_show_bin,
  output logic [7:0] disp_hex,
  output logic [7:0] disp_bin,
  output logic warn_icon,
  output logic mains_icon,
  output logic batt_sel,
  output logic energy_hold,
  output logic volume_hold
);
  if (SESSION_CYC < 2 || ALT_CYC < 2 || HDR_LEN < 1 || HDR_LEN > 255 ||
      CREDIT_MAX < `MSF_DAILY_CREDIT || CREDIT_MAX > 255 ||
      DAY_CYC < 48'h2) begin : g_bad_param
    $error("msf_top: parameter out of range");
  end

  localparam logic [31:0] SESS_M1 = 32'(SESSION_CYC - 1);
  localparam logic [31:0] ALT_M1 = 32'(ALT_CYC - 1);
  localparam logic [7:0] HDR_M1 = 8'(HDR_LEN - 1);
  localparam logic [8:0] CRED_MAX = 9'(CREDIT_MAX);
  localparam logic [8:0] CRED_DAY = 9'(`MSF_DAILY_CREDIT);

  msf_uart_if uif ();

  msf_uart #(.BAUD_DIV(BAUD_DIV)) u_uart (
    .pclk(pclk),
    .presetn(presetn),
    .rxd(opt_rxd),
    .txd(opt_txd),
    .u(uif.uart)
  );

  // ========================================================================
  // register file
  logic [7:0] cause_reg, cause_next;
  logic [7:0] bin_reg, bin_next;
  logic opt_en_reg, opt_en_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [7:0] tx_data_reg, tx_data_next;
  logic tx_start_reg, tx_start_next;
  logic [8:0] rx_hold_reg, rx_hold_next;
  logic wr_en, rd_setup, addr_ok;
  logic [7:0] credit_reg;
  logic show_bin_reg;

  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign addr_ok = paddr == `MSF_ADDR_CAUSE || paddr == `MSF_ADDR_CTRL ||
    paddr == `MSF_ADDR_STAT || paddr == `MSF_ADDR_TXDATA ||
    paddr == `MSF_ADDR_RXDATA;

  always_comb begin
    // set wins over a write-one clear in the same cycle
    cause_next = cause_reg;
    if (wr_en && paddr == `MSF_ADDR_CAUSE) begin
      cause_next = cause_reg & ~pwdata[7:0];
    end
    cause_next = cause_next | cause_in;
    bin_next = msf_pkg::msf_rev8(cause_next);
    opt_en_next = opt_en_reg;
    if (wr_en && paddr == `MSF_ADDR_CTRL) begin
      opt_en_next = pwdata[`MSF_CTRL_OPT_EN];
    end
    tx_data_next = tx_data_reg;
    tx_start_next = 1'b0;
    if (wr_en && paddr == `MSF_ADDR_TXDATA && !uif.tx_busy) begin
      tx_data_next = pwdata[7:0];
      tx_start_next = 1'b1;
    end
    rx_hold_next = rx_hold_reg;
    if (uif.rx_valid && !uif.rx_err) begin
      rx_hold_next = {1'b1, uif.rx_data};
    end else if (psel && penable && !pwrite &&
                 paddr == `MSF_ADDR_RXDATA) begin
      rx_hold_next = {1'b0, rx_hold_reg[7:0]};
    end
    prdata_next = prdata_reg;
    if (rd_setup) begin
      prdata_next = 32'h0000_0000;
      case (paddr)
        `MSF_ADDR_CAUSE: prdata_next[7:0] = cause_reg;
        `MSF_ADDR_CTRL: prdata_next[`MSF_CTRL_OPT_EN] = opt_en_reg;
        `MSF_ADDR_STAT: begin
          prdata_next[`MSF_STAT_OPEN] = session_open;
          prdata_next[`MSF_STAT_MAINS] = ext_supply_det;
          prdata_next[`MSF_STAT_TXBUSY] = uif.tx_busy;
          prdata_next[`MSF_STAT_SHOWBIN] = show_bin_reg;
          prdata_next[`MSF_STAT_CRED_LSB +: 8] = credit_reg;
        end
        `MSF_ADDR_TXDATA: prdata_next[7:0] = tx_data_reg;
        `MSF_ADDR_RXDATA: prdata_next[8:0] = rx_hold_reg;
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_reg <= 8'h00;
      bin_reg <= 8'h00;
      opt_en_reg <= `MSF_CTRL_RESET;
      prdata_reg <= 32'h0000_0000;
      tx_data_reg <= 8'h00;
      tx_start_reg <= 1'b0;
      rx_hold_reg <= 9'h000;
    end else begin
      cause_reg <= cause_next;
      bin_reg <= bin_next;
      opt_en_reg <= opt_en_next;
      prdata_reg <= prdata_next;
      tx_data_reg <= tx_data_next;
      tx_start_reg <= tx_start_next;
      rx_hold_reg <= rx_hold_next;
    end
  end

  assign uif.tx_data = tx_data_reg;
  assign uif.tx_start = tx_start_reg;
  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // ========================================================================
  // session, budget and display alternation
  msf_pkg::msf_sess_t st_reg, st_next;
  logic [7:0] hdr_reg, hdr_next;
  logic [31:0] sess_reg, sess_next;
  logic [47:0] day_reg, day_next;
  logic [31:0] alt_reg, alt_next;
  logic [7:0] credit_next;
  logic show_bin_next;
  logic wake_byte, open_evt, day_tick;
  logic [8:0] cred_sum;

  assign wake_byte = uif.rx_valid && !uif.rx_err &&
    uif.rx_data == `MSF_WAKE_BYTE;
  assign day_tick = day_reg == 48'h0;

  always_comb begin
    st_next = st_reg;
    hdr_next = hdr_reg;
    sess_next = sess_reg;
    open_evt = 1'b0;
    case (st_reg)
      msf_pkg::sess_idle, msf_pkg::sess_hdr: begin
        if (uif.rx_valid) begin
          if (!wake_byte) begin
            st_next = msf_pkg::sess_idle;
            hdr_next = 8'h00;
          end else if (hdr_reg == HDR_M1) begin
            // header without credit or enable is dropped silently
            st_next = msf_pkg::sess_idle;
            hdr_next = 8'h00;
            if (opt_en_reg && credit_reg != 8'h00) begin
              open_evt = 1'b1;
              st_next = msf_pkg::sess_open;
              sess_next = SESS_M1;
            end
          end else begin
            st_next = msf_pkg::sess_hdr;
            hdr_next = hdr_reg + 8'h01;
          end
        end
      end
      msf_pkg::sess_open: begin
        if (exch_ok) begin
          sess_next = SESS_M1;
        end else if (sess_reg == 32'h0) begin
          st_next = msf_pkg::sess_idle;
        end else begin
          sess_next = sess_reg - 32'h1;
        end
      end
      default: begin
        st_next = msf_pkg::sess_idle;
        hdr_next = 8'h00;
      end
    endcase
    day_next = day_tick ? DAY_CYC - 48'h1 : day_reg - 48'h1;
    // credits saturate at the cap so long idle periods cannot overflow
    cred_sum = {1'b0, credit_reg} + (day_tick ? CRED_DAY : 9'h000);
    if (cred_sum > CRED_MAX) begin
      cred_sum = CRED_MAX;
    end
    if (open_evt) begin
      cred_sum = cred_sum - 9'h001;
    end
    credit_next = cred_sum[7:0];
    show_bin_next = show_bin_reg;
    alt_next = alt_reg - 32'h1;
    if (alt_reg == 32'h0) begin
      alt_next = ALT_M1;
      show_bin_next = !show_bin_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= msf_pkg::sess_idle;
      hdr_reg <= 8'h00;
      sess_reg <= 32'h0;
      day_reg <= 48'h0;
      alt_reg <= 32'h0;
      credit_reg <= 8'(`MSF_DAILY_CREDIT);
      show_bin_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      hdr_reg <= hdr_next;
      sess_reg <= sess_next;
      day_reg <= day_next;
      alt_reg <= alt_next;
      credit_reg <= credit_next;
      show_bin_reg <= show_bin_next;
    end
  end

  // ========================================================================
  // outputs
  assign session_open = st_reg == msf_pkg::sess_open;
  assign disp_on = session_open;
  assign disp_show_bin = show_bin_reg;
  assign disp_hex = cause_reg;
  assign disp_bin = bin_reg;
  assign warn_icon = |cause_reg;
  assign mains_icon = ext_supply_det;
  assign batt_sel = !ext_supply_det;
  assign energy_hold = |(cause_reg & `MSF_ENERGY_MASK);
  assign volume_hold = |(cause_reg & `MSF_VOLUME_MASK);

  // ========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_wake_after_hdr: assert property (
    $rose(session_open) |-> $past(wake_byte) && $past(hdr_reg) == HDR_M1)
    else $error("session opened without a full header");
  a_open_full_win: assert property (
    $rose(session_open) |-> sess_reg == SESS_M1)
    else $error("session window not loaded at open");
  a_exch_reload: assert property (
    session_open && exch_ok |=> session_open && sess_reg == SESS_M1)
    else $error("exchange did not reload session timer");
  a_expiry_close: assert property (
    session_open && sess_reg == 32'h0 && !exch_ok |=> !session_open && !disp_on)
    else $error("session not closed at expiry");
  a_credit_spend: assert property (
    open_evt && !day_tick |=> credit_reg == $past(credit_reg) - 8'h01)
    else $error("open did not spend one credit");
  a_credit_accum: assert property (
    day_tick && !open_evt && {1'b0, credit_reg} + CRED_DAY <= CRED_MAX
    |=> credit_reg == $past(credit_reg) + 8'(`MSF_DAILY_CREDIT))
    else $error("daily credit not added");
  a_cause_latch: assert property (
    |cause_in |=> (cause_reg & $past(cause_in)) == $past(cause_in))
    else $error("cause bit lost");
  a_bin_order: assert property (
    ##1 disp_bin[0] == disp_hex[7] && disp_bin[7] == disp_hex[0])
    else $error("binary display order wrong");
  a_warn_icon: assert property (
    warn_icon == (disp_hex != 8'h00))
    else $error("warning icon mismatch");
  a_energy_freeze: assert property (
    cause_reg[`MSF_BIT_ELEC] || cause_reg[`MSF_BIT_S1OPEN] |-> energy_hold)
    else $error("energy not frozen");
  a_flow_freeze: assert property (
    cause_reg[`MSF_BIT_FLOW] |-> energy_hold && volume_hold)
    else $error("flow fault did not freeze registers");
  a_info_only: assert property (
    (cause_reg & 8'h3F) == 8'h00 |-> !energy_hold && !volume_hold)
    else $error("informational cause froze a register");
  a_mains_batt: assert property (
    mains_icon != batt_sel && mains_icon == ext_supply_det)
    else $error("supply indication wrong");

  c_open: cover property ($rose(session_open));
  c_extend: cover property (session_open && exch_ok ##1 session_open);
  c_close: cover property ($fell(session_open));
  c_multi: cover property ($countones(cause_reg) > 1);
endmodule : msf_top

// ===== verification/msf_head.sv
// Purpose: optical reading head that exchanges characters with the meter
// Assumes: 8N1, lsb first, BIT_CYC pclk cycles per bit
// Notes: line idles high; bad_stop sends a low stop bit
`timescale 1ns/1ps
`include "msf_map.svh"
module msf_head #(
  parameter int BIT_CYC = 8
) (
  // clock
  input wire logic pclk,
  // lines toward and from the meter
  output logic opt_rxd,
  input wire logic opt_txd
);
  initial begin
    opt_rxd = 1'b1;
  end

  // ==========================================================
  // characters
  task automatic send_byte(input logic [7:0] b, input logic bad_stop);
    logic [9:0] frame;
    frame = {~bad_stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      opt_rxd <= frame[i];
      repeat (BIT_CYC - 1) @(posedge pclk);
    end
    // back to idle so a bad stop does not look like a start
    @(posedge pclk);
    opt_rxd <= 1'b1;
    repeat (BIT_CYC) @(posedge pclk);
  endtask : send_byte

  task automatic send_header(input int n);
    for (int i = 0; i < n; i++) begin
      send_byte(`MSF_WAKE_BYTE, 1'b0);
    end
  endtask : send_header

  // ==========================================================
  // characters from the meter, sampled mid-bit
  task automatic recv_byte(output logic [7:0] b, output logic stop);
    b = 8'h00;
    while (opt_txd !== 1'b0) @(posedge pclk);
    repeat (BIT_CYC / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge pclk);
      b[i] = opt_txd;
    end
    repeat (BIT_CYC) @(posedge pclk);
    stop = opt_txd;
  endtask : recv_byte
endmodule : msf_head

// ===== verification/msf_tb_top.sv
// Purpose: self-checking bench of the status byte and optical session
// Assumes: shortened timing parameters, zero wait state apb
// Notes: credit model avoids reads close to a day tick
`timescale 1ns/1ps
`include "msf_map.svh"
module msf_tb_top;
  localparam int SESS = 200;
  localparam int ALT = 50;
  localparam int DAY = 1000;
  localparam int HDR = 2;
  localparam int BDIV = 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic opt_rxd, opt_txd, exch_ok, ext_supply_det, err, stop;
  logic [7:0] cause_in, disp_hex, disp_bin, v, m;
  logic session_open, disp_on, disp_show_bin, warn_icon, mains_icon;
  logic batt_sel, energy_hold, volume_hold;
  int miscompares, samples_checked, credits, day_cyc, cnt;

  msf_top #(.BAUD_DIV(BDIV), .SESSION_CYC(SESS), .ALT_CYC(ALT),
    .DAY_CYC(48'(DAY)), .HDR_LEN(HDR), .CREDIT_MAX(`MSF_CREDIT_MAX))
  i_msf_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .opt_rxd(opt_rxd),
    .opt_txd(opt_txd), .exch_ok(exch_ok), .cause_in(cause_in),
    .ext_supply_det(ext_supply_det), .session_open(session_open),
    .disp_on(disp_on), .disp_show_bin(disp_show_bin), .disp_hex(disp_hex),
    .disp_bin(disp_bin), .warn_icon(warn_icon), .mains_icon(mains_icon),
    .batt_sel(batt_sel), .energy_hold(energy_hold),
    .volume_hold(volume_hold));
  msf_head #(.BIT_CYC(BDIV)) i_msf_head (.pclk(pclk), .opt_rxd(opt_rxd),
    .opt_txd(opt_txd));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ==========================================================
  // credit model: tick on first edge after release, then every DAY
  always @(posedge pclk) begin
    if (presetn === 1'b1) begin
      if (day_cyc % DAY == 0) begin
        credits = credits + `MSF_DAILY_CREDIT;
        if (credits > `MSF_CREDIT_MAX) credits = `MSF_CREDIT_MAX;
      end
      day_cyc++;
    end
  end

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic check_disp(input logic [7:0] c);
    logic [7:0] b;
    for (int k = 0; k < 8; k++) b[k] = c[7 - k];
    #1;
    chk(disp_hex, c);
    chk(disp_bin, b);
    chk(warn_icon, |c);
    chk(energy_hold, |(c & 8'h3F));
    chk(volume_hold, c[4]);
    apb(1'b0, `MSF_ADDR_CAUSE, 32'h0);
    chk(rd, c);
  endtask : check_disp

  task automatic set_cause(input logic [7:0] c);
    @(posedge pclk);
    cause_in <= c;
    @(posedge pclk);
    cause_in <= 8'h00;
    @(posedge pclk);
    check_disp(c);
  endtask : set_cause

  task automatic wait_sess(input logic lvl, input int lim);
    cnt = 0;
    while (session_open !== lvl && cnt < lim) begin
      @(posedge pclk);
      #1;
      cnt++;
    end
  endtask : wait_sess

  task automatic open_sess();
    fork
      i_msf_head.send_header(HDR);
      wait_sess(1'b1, 60 * BDIV);
    join_any
    chk(session_open, 1'b1);
    chk(disp_on, 1'b1);
    credits--;
  endtask : open_sess

  task automatic wait_alt();
    logic t;
    #1;
    t = disp_show_bin;
    cnt = 0;
    while (disp_show_bin === t && cnt < 4 * ALT) begin
      @(posedge pclk);
      #1;
      cnt++;
    end
  endtask : wait_alt

  task automatic cred_chk();
    // a tick inside the read would make the model race the design
    while (day_cyc % DAY > DAY - 8 || day_cyc % DAY == 0) @(posedge pclk);
    apb(1'b0, `MSF_ADDR_STAT, 32'h0);
    chk(rd[15:8], 32'(credits));
    chk(rd[`MSF_STAT_OPEN], 1'b0);
    chk(rd[`MSF_STAT_MAINS], ext_supply_det);
  endtask : cred_chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hE630B7FF));
    {presetn, psel, penable, pwrite, exch_ok, ext_supply_det} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    cause_in = 8'h00;
    credits = `MSF_DAILY_CREDIT;
    {day_cyc, miscompares, samples_checked} = {32'h0, 32'h0, 32'h0};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `MSF_ADDR_CTRL, 32'h0);
    chk(rd, 32'h1);
    cred_chk();
    apb(1'b1, 12'h0FC, 32'hFFFF);
    chk(err, 1'b1);
    apb(1'b0, 12'h0FC, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      set_cause(8'h01 << i);
      apb(1'b1, `MSF_ADDR_CAUSE, 32'hFF);
    end
    v = 8'($urandom);
    set_cause(v);
    m = 8'($urandom);
    apb(1'b1, `MSF_ADDR_CAUSE, {24'h0, m});
    check_disp(v & ~m);
    // transmit path; a second write while busy is dropped
    v = 8'($urandom);
    apb(1'b1, `MSF_ADDR_TXDATA, {24'h0, v});
    fork
      i_msf_head.recv_byte(m, stop);
      begin
        apb(1'b1, `MSF_ADDR_TXDATA, {24'h0, ~v});
        apb(1'b0, `MSF_ADDR_STAT, 32'h0);
        chk(rd[`MSF_STAT_TXBUSY], 1'b1);
        apb(1'b0, `MSF_ADDR_TXDATA, 32'h0);
        chk(rd, {24'h0, v});
      end
    join
    chk(m, v);
    chk(stop, 1'b1);
    repeat (4) begin
      @(posedge pclk);
      ext_supply_det <= 1'($urandom);
      @(posedge pclk);
      #1;
      chk(mains_icon, ext_supply_det);
      chk(batt_sel, !ext_supply_det);
    end
    wait_alt();
    wait_alt();
    chk(cnt, ALT);
    // refused: bad stop bits, broken run, port disabled
    i_msf_head.send_byte(8'h55, 1'b1);
    i_msf_head.send_byte(8'h55, 1'b1);
    i_msf_head.send_byte(8'hAA, 1'b0);
    i_msf_head.send_byte(8'h55, 1'b0);
    apb(1'b1, `MSF_ADDR_CTRL, 32'h0);
    i_msf_head.send_header(HDR);
    chk(session_open, 1'b0);
    apb(1'b0, `MSF_ADDR_RXDATA, 32'h0);
    chk(rd, 32'h155);
    apb(1'b0, `MSF_ADDR_RXDATA, 32'h0);
    chk(rd, 32'h055);
    apb(1'b1, `MSF_ADDR_CTRL, 32'h1);
    i_msf_head.send_byte(8'hAA, 1'b0);
    open_sess();
    wait_sess(1'b0, 3 * SESS);
    chk(cnt, SESS);
    chk(disp_on, 1'b0);
    cred_chk();
    open_sess();
    repeat (100) @(posedge pclk);
    exch_ok <= 1'b1;
    @(posedge pclk);
    exch_ok <= 1'b0;
    wait_sess(1'b0, 3 * SESS);
    chk(cnt, SESS);
    @(posedge pclk);
    exch_ok <= 1'b1;
    @(posedge pclk);
    exch_ok <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(session_open, 1'b0);
    repeat (2 * DAY) @(posedge pclk);
    cred_chk();
    test_done();
  end

  initial begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    test_done();
  end
endmodule : msf_tb_top
